/* File: hdl/bytmr_prescale.v */
`timescale 1ns/1ps
`default_nettype none
`include "bytmr_defs.vh"
// clock prescaler: one tick every 1, 2, 4 or 8 system clocks
module bytmr_prescale (
  input wire aclk,
  input wire aresetn,
  input wire run,
  input wire [1:0] clk_sel,
  output reg tick
);
  reg [`BYTMR_PRESC_W-1:0] div_reg;
  reg [`BYTMR_PRESC_W-1:0] mask;

  // mask of low bits that must all be one for a tick
  always @* begin
    case (clk_sel)
      2'b00: mask = 3'h0;
      2'b01: mask = 3'h1;
      2'b10: mask = 3'h3;
      default: mask = 3'h7;
    endcase
  end

  // divider is held clear while stopped so each start is alike
  always @(posedge aclk) begin
    if (!aresetn || !run) begin
      div_reg <= 3'h0;
      tick <= 1'b0;
    end else begin
      div_reg <= div_reg + 3'h1;
      tick <= ((div_reg & mask) == mask);
    end
  end
endmodule
`default_nettype wire

/* File: hdl/bytmr_top.v */
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "bytmr_defs.vh"
module bytmr_top (
  input wire aclk,
  input wire aresetn,
  input wire stop_recovery,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire capture_event,
  output reg shared_timer_output_pin,
  output reg timeout_irq,
  output reg capture_irq
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  reg outsel_reg;
  reg toie_reg;
  reg capie_reg;
  reg [1:0] clksel_reg;
  reg toflag_reg;
  reg single_reg;
  reg run_reg;
  reg [7:0] reload_reg;
  reg [7:0] count_reg;
  reg port_reg;
  reg tout_reg;
  reg aw_hold_reg;
  reg w_hold_reg;
  reg [7:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg cap_s1_reg;
  reg cap_s2_reg;
  reg cap_s3_reg;
  reg cap_lvl_reg;
  wire tick;
  wire do_write;
  wire wr_ctrl;
  wire terminal;
  wire cap_rise;

  // word-aligned decode shared by read and write paths
  function [2:0] dec;
    input [31:0] addr;
    begin
      case ({addr[31:4], 2'b00, addr[1:0]} == 32'h0 ? {28'h0, addr[3:0]} : 32'hffffffff)
        {24'h0, `BYTMR_CTRL_OFF}: dec = 3'h1;
        {24'h0, `BYTMR_RELOAD_OFF}: dec = 3'h2;
        {24'h0, `BYTMR_COUNT_OFF}: dec = 3'h3;
        {24'h0, `BYTMR_PORT_OFF}: dec = 3'h4;
        default: dec = 3'h0;
      endcase
    end
  endfunction

  bytmr_prescale u_presc (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run_reg),
    .clk_sel(clksel_reg),
    .tick(tick)
  );

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign wr_ctrl = do_write && (dec({24'h0, awaddr_reg}) == 3'h1) && wstrb_reg[0];
  assign terminal = run_reg && tick && (count_reg == 8'h00);

  // address and data are latched in either order, answer one cycle after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BYTMR_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr[7:0];
        if (s_axi_awaddr[31:8] != 24'h0) awaddr_reg <= 8'h03;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (dec({24'h0, awaddr_reg}) == 3'h0) ? `BYTMR_RESP_SLVERR : `BYTMR_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // control register and counter
  // ----------------------------------------
  // power-on clears all but reload and count, which load 8'hff; stop recovery spares enables, prescale, flag
  always @(posedge aclk) begin
    if (!aresetn) begin
      toie_reg <= 1'b0;
      capie_reg <= 1'b0;
      clksel_reg <= 2'b00;
      toflag_reg <= 1'b0;
      outsel_reg <= 1'b0;
      single_reg <= 1'b0;
      run_reg <= 1'b0;
      reload_reg <= `BYTMR_RELOAD_RST;
      count_reg <= `BYTMR_RELOAD_RST;
      port_reg <= 1'b0;
      tout_reg <= 1'b0;
    end else if (stop_recovery) begin
      outsel_reg <= 1'b0;
      single_reg <= 1'b0;
      run_reg <= 1'b0;
      count_reg <= reload_reg;
      tout_reg <= 1'b0;
      if (terminal) toflag_reg <= 1'b1;
    end else begin
      if (wr_ctrl) begin
        outsel_reg <= wdata_reg[`BYTMR_OUTSEL_BIT];
        toie_reg <= wdata_reg[`BYTMR_TOIE_BIT];
        capie_reg <= wdata_reg[`BYTMR_CAPIE_BIT];
        clksel_reg <= wdata_reg[`BYTMR_CLKSEL_HI:`BYTMR_CLKSEL_LO];
        single_reg <= wdata_reg[`BYTMR_SINGLE_BIT];
        run_reg <= wdata_reg[`BYTMR_RUN_BIT];
        // a fresh start reloads so a stale count is never resumed
        if (wdata_reg[`BYTMR_RUN_BIT] && !run_reg) count_reg <= reload_reg;
      end
      if (do_write && wstrb_reg[0] && dec({24'h0, awaddr_reg}) == 3'h2) reload_reg <= wdata_reg[7:0];
      if (do_write && wstrb_reg[0] && dec({24'h0, awaddr_reg}) == 3'h4) port_reg <= wdata_reg[0];
      // set wins over a write-one clear in the same cycle
      if (terminal) begin
        toflag_reg <= 1'b1;
      end else if (wr_ctrl && wdata_reg[`BYTMR_TOFLAG_BIT]) begin
        toflag_reg <= 1'b0;
      end
      if (terminal) begin
        tout_reg <= !tout_reg;
        count_reg <= reload_reg;
        if (single_reg) run_reg <= 1'b0;
      end else if (run_reg && tick && !(wr_ctrl && !run_reg)) begin
        count_reg <= count_reg - 8'h01;
      end
    end
  end

  // ----------------------------------------
  // pin and interrupt requests
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      cap_s1_reg <= 1'b0;
      cap_s2_reg <= 1'b0;
      cap_s3_reg <= 1'b0;
      cap_lvl_reg <= 1'b0;
      shared_timer_output_pin <= 1'b0;
      timeout_irq <= 1'b0;
      capture_irq <= 1'b0;
    end else begin
      cap_s1_reg <= capture_event;
      cap_s2_reg <= cap_s1_reg;
      cap_s3_reg <= cap_s2_reg;
      // level moves only when two stages agree, so a one-stage glitch is dropped
      if (cap_s2_reg == cap_s3_reg) cap_lvl_reg <= cap_s3_reg;
      shared_timer_output_pin <= outsel_reg ? tout_reg : port_reg;
      timeout_irq <= terminal && toie_reg;
      capture_irq <= cap_rise && capie_reg;
    end
  end
  // rise counts once the agreed level turns high; reset level matches idle low pin
  assign cap_rise = cap_s2_reg && cap_s3_reg && !cap_lvl_reg;

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  // one read at a time: arready pulses, data follows next cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `BYTMR_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `BYTMR_RESP_OKAY;
        case (dec(s_axi_araddr))
          3'h1: s_axi_rdata <= {24'h0, run_reg, single_reg, toflag_reg, clksel_reg,
                                capie_reg, toie_reg, outsel_reg};
          3'h2: s_axi_rdata <= {24'h0, reload_reg};
          3'h3: s_axi_rdata <= {24'h0, count_reg};
          3'h4: s_axi_rdata <= {31'h0, port_reg};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `BYTMR_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: inc/bytmr_defs.vh */
`ifndef BYTMR_DEFS_VH
`define BYTMR_DEFS_VH
// ----------------------------------------
// register map
// ----------------------------------------
`define BYTMR_CTRL_OFF 8'h00
`define BYTMR_RELOAD_OFF 8'h04
`define BYTMR_COUNT_OFF 8'h08
`define BYTMR_PORT_OFF 8'h0c
// ----------------------------------------
// control field positions
// ----------------------------------------
`define BYTMR_OUTSEL_BIT 0
`define BYTMR_TOIE_BIT 1
`define BYTMR_CAPIE_BIT 2
`define BYTMR_CLKSEL_LO 3
`define BYTMR_CLKSEL_HI 4
`define BYTMR_TOFLAG_BIT 5
`define BYTMR_SINGLE_BIT 6
`define BYTMR_RUN_BIT 7
// ----------------------------------------
// reset values and prescaler width
// ----------------------------------------
`define BYTMR_RELOAD_RST 8'hff
`define BYTMR_PRESC_W 3
// ----------------------------------------
// axi responses
// ----------------------------------------
`define BYTMR_RESP_OKAY 2'b00
`define BYTMR_RESP_SLVERR 2'b10
`endif

/* File: test/bytmr_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module bytmr_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic stop_recovery,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic shared_timer_output_pin,
  input wire logic timeout_irq,
  input wire logic capture_irq
);
  // one clock domain, synchronous reset
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_RST: assert property (disable iff (1'b0)
    !aresetn |=> !shared_timer_output_pin && !timeout_irq && !capture_irq && !s_axi_rvalid)
    else $error("outputs not cleared by reset");
  AST_TO_PULSE: assert property (timeout_irq |=> !timeout_irq)
    else $error("timeout request wider than one cycle");
  AST_CAP_PULSE: assert property (capture_irq |=> !capture_irq)
    else $error("capture request wider than one cycle");
  // a recovery halts the timer, so no terminal count may follow soon
  AST_SR_QUIET: assert property (stop_recovery |-> ##3 (!timeout_irq) [*6])
    else $error("timeout request after stop recovery");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_R_ERR: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0)
    else $error("refused read returned data");
endmodule

bind bytmr_top bytmr_chk u_bytmr_chk (.aclk, .aresetn, .stop_recovery, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .shared_timer_output_pin, .timeout_irq, .capture_irq);
`default_nettype wire

/* File: test/tb_bytmr_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_bytmr_top;
  logic aclk = 1'h0, aresetn = 1'h0, stop_recovery = 1'h0, capture_event = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [1:0] rsp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire shared_timer_output_pin, timeout_irq, capture_irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer fails = 0, total_checks = 0, k, t, c;
  // rows: control byte to write, expected terminal-count period in cycles
  logic [15:0] rows [4] = '{16'h8204, 16'h8a08, 16'h9210, 16'h9a20};

  bytmr_top u_bytmr_top (.aclk, .aresetn, .stop_recovery, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .capture_event, .shared_timer_output_pin, .timeout_irq, .capture_irq);

  // 125 mhz
  always #4 aclk = ~aclk;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks++;
      if (got !== exp) begin
        fails++;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  // both channels offered at once, each released when taken
  // bready rises after the first edge so back-to-back calls never drive it twice in one step
  task wr(input [7:0] a, input [7:0] d);
    begin
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
        if (!s_axi_bvalid) s_axi_bready <= 1'h1;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      rsp = s_axi_bresp;
    end
  endtask

  // rready follows rvalid by a cycle, so the slave must hold its read data
  task rd(input [7:0] a, input [31:0] e);
    begin
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'h1;
      do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'h0;
        if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'h1;
      end while (!(s_axi_rvalid && s_axi_rready));
      s_axi_rready <= 1'h0;
      rsp = s_axi_rresp;
      chk(s_axi_rdata, e);
    end
  endtask

  // counts timeout and capture pulses and pin toggles over n cycles
  task cnt(input integer n);
    logic p;
    begin
      k = 0;
      t = 0;
      c = 0;
      p = shared_timer_output_pin;
      repeat (n) begin
        @(posedge aclk);
        k += timeout_irq;
        c += capture_irq;
        t += (shared_timer_output_pin != p);
        p = shared_timer_output_pin;
      end
    end
  endtask

  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    fails++;
    wrap_up;
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    rd(8'h00, 32'h0);
    chk(shared_timer_output_pin, 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(8'h00, 8'h20);
      wr(8'h04, 8'h03);
      wr(8'h00, rows[i][15:8]);
      do @(posedge aclk); while (!timeout_irq);
      k = 0;
      do begin
        @(posedge aclk);
        k++;
      end while (!timeout_irq);
      chk(k, rows[i][7:0]);
      rd(8'h00, rows[i][15:8] | 8'h20);
      $display("row %0d done", i);
    end
    // writing zero keeps the flag, writing one clears it
    wr(8'h00, 8'h00);
    rd(8'h00, 32'h20);
    wr(8'h00, 8'h20);
    rd(8'h00, 32'h0);
    wr(8'h00, 8'hc2);
    cnt(64);
    chk(k, 32'h1);
    wr(8'h00, 8'h20);
    wr(8'h00, 8'h80);
    cnt(64);
    chk(k, 32'h0);
    rd(8'h00, 32'ha0);
    $display("flag and mode tests done");
    // pin follows the timer, then the port latch
    wr(8'h0c, 8'h01);
    wr(8'h00, 8'h81);
    cnt(64);
    chk(t > 8, 32'h1);
    wr(8'h00, 8'h00);
    repeat (2) @(posedge aclk);
    chk(shared_timer_output_pin, 32'h1);
    for (int e = 0; e < 2; e++) begin
      wr(8'h00, {5'h0, e[0], 2'h0});
      capture_event <= 1'h1;
      cnt(12);
      capture_event <= 1'h0;
      chk(c, e);
    end
    $display("pin and capture tests done");
    // partial reset keeps enables, clock select and flag
    wr(8'h00, 8'h9f);
    cnt(40);
    stop_recovery <= 1'h1;
    @(posedge aclk);
    stop_recovery <= 1'h0;
    rd(8'h00, 32'h3e);
    chk(shared_timer_output_pin, 32'h1);
    rd(8'h10, 32'h0);
    chk(rsp, 32'h2);
    wr(8'h10, 8'h55);
    chk(rsp, 32'h2);
    // a write with its low byte lane off must leave the reload value alone
    s_axi_wstrb <= 4'h0;
    wr(8'h04, 8'h11);
    s_axi_wstrb <= 4'h1;
    rd(8'h04, 32'h3);
    aresetn <= 1'h0;
    @(posedge aclk);
    aresetn <= 1'h1;
    rd(8'h00, 32'h0);
    chk(shared_timer_output_pin, 32'h0);
    rd(8'h08, 32'hff);
    $display("recovery and map tests done");
    wrap_up;
  end
endmodule
`default_nettype wire
